// ==== dv/testbench.sv ====
// testbench for the frame engine
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic        mclk = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  rx_data = 8'h00;
  logic        rx_valid = 1'b0;
  logic        broadcast = 1'b0;
  logic [31:0] reg_rdata = 32'h0;
  logic [7:0]  tx_data;
  logic        tx_valid, tx_ready, reg_wr, reg_rd, frame_error;
  logic [11:0] reg_addr, wr_addr;
  logic [31:0] reg_wdata, wr_data;
  int          failures = 0, compares = 0, cycles = 0, wr_seen = 0, err_seen = 0, rd_seen = 0;

  urf_engine DUT (.mclk(mclk), .reset(reset), .rx_data(rx_data), .rx_valid(rx_valid),
    .broadcast(broadcast), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .frame_error(frame_error));
  urf_host host (.mclk(mclk), .reset(reset), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));

  always #5 mclk = ~mclk;
  // ceiling well above the longest burst; a hang ends as a failure
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      wrap_up();
    end
  end
  // register file stand-in; read data is its own address under a 0x5A5A5 pattern for easy expectation
  always @(posedge mclk)
  begin
    if (reg_rd)
    begin
      rd_seen++;
      reg_rdata <= {20'h5A5A5, reg_addr};
    end
    if (reg_wr)
    begin
      wr_seen++;
      wr_addr = reg_addr;
      wr_data = reg_wdata;
    end
    if (frame_error)
      err_seen++;
  end

  function automatic logic [7:0] csum(input logic [7:0] q [$]);
    logic [7:0] s;
    s = 8'h00;
    foreach (q[i])
      s = s + q[i];
    return ~s + 8'h33;
  endfunction : csum

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  // one byte per two cycles, then room for the check stage
  task automatic send(input logic [7:0] h, c, a, input logic [31:0] d, input logic [7:0] bad);
    logic [7:0] f [$];
    f = {h, c, a, d[7:0], d[15:8], d[23:16], d[31:24]};
    f.push_back(csum(f) + bad);
    foreach (f[i])
    begin
      rx_data  <= f[i];
      rx_valid <= 1'b1;
      @(posedge mclk);
      rx_valid <= 1'b0;
      @(posedge mclk);
    end
    repeat (4) @(posedge mclk);
  endtask : send

  // waits for the answer, then lingers to catch surplus bytes
  task automatic answer(input logic [7:0] e [$]);
    for (int k = 0; k < 5000 && host.got.size() < e.size(); k++)
      @(posedge mclk);
    repeat (40) @(posedge mclk);
    chk("answer length", e.size(), host.got.size());
    foreach (e[i])
      if (i < host.got.size())
        chk("answer byte", e[i], host.got[i]);
    host.got.delete();
  endtask : answer

  task automatic t_write();
    logic [7:0] e [$];
    send(8'h7D, 8'hA2, 8'h5C, 32'h1234_5678, 8'h00);
    e = {8'h7D, 8'hA2, 8'h5C};
    e.push_back(csum(e));
    answer(e);
    chk("write address", 32'hA5C, {20'h0, wr_addr});
    chk("write data", 32'h1234_5678, wr_data);
  endtask : t_write

  task automatic t_read(input logic [7:0] n);
    logic [7:0]  e [$];
    logic [31:0] d;
    logic [7:0]  w;
    int          r0;
    w = (n == 8'h00) ? 8'h01 : n;
    r0 = rd_seen;
    send(8'h7D, 8'h11, 8'hF0, {24'h0, n}, 8'h00);
    e = {8'h7D, 8'h11, w};
    for (int i = 0; i < w; i++)
    begin
      d = {20'h5A5A5, 12'h1F0 + 12'(i)};
      e = {e, d[7:0], d[15:8], d[23:16], d[31:24]};
    end
    e.push_back(csum(e));
    answer(e);
    chk("read strobes", w, rd_seen - r0);
  endtask : t_read

  task automatic t_bad();
    logic [7:0] e [$];
    send(8'h7D, 8'hA2, 8'h10, 32'hDEAD_BEEF, 8'h01);
    send(8'h7C, 8'hA2, 8'h10, 32'hDEAD_BEEF, 8'h00);
    send(8'h7D, 8'hA3, 8'h10, 32'hDEAD_BEEF, 8'h00);
    answer(e);
    chk("dropped", 3, err_seen);
    chk("write count", 1, wr_seen);
  endtask : t_bad

  task automatic t_bcast();
    logic [7:0] e [$];
    broadcast <= 1'b1;
    send(8'h7D, 8'h32, 8'h07, 32'h0BAD_F00D, 8'h00);
    answer(e);
    broadcast <= 1'b0;
    chk("bcast data", 32'h0BAD_F00D, wr_data);
    chk("bcast address", 32'h307, {20'h0, wr_addr});
    chk("bcast writes", 2, wr_seen);
  endtask : t_bcast

  task automatic wrap_up();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  initial
  begin
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    t_write();
    t_read(8'h00);
    t_read(8'h03);
    t_read(8'hFF);
    t_bad();
    t_bcast();
    wrap_up();
  end
endmodule : testbench

bind urf_engine urf_engine_props u_props (.mclk(mclk), .reset(reset), .rx_valid(rx_valid),
  .broadcast(broadcast), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .frame_error(frame_error));
`default_nettype wire

// ==== dv/urf_engine_props.sv ====
// port assertions for the frame engine
`timescale 1ns/10ps
`default_nettype none
module urf_engine_props
(
  input wire logic       mclk,       // clock
  input wire logic       reset,      // reset
  input wire logic       rx_valid,   // byte in
  input wire logic       broadcast,  // no answer
  input wire logic [7:0] tx_data,    // byte out
  input wire logic       tx_valid,   // offered
  input wire logic       tx_ready,   // taken
  input wire logic       reg_wr,     // write
  input wire logic       reg_rd,     // read
  input wire logic       frame_error // dropped
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // an answer opens with the head byte
  sequence head_out;
    tx_valid && tx_data == 8'h7D;
  endsequence
  // a write follows the last byte closely, never earlier
  sequence byte_lately;
    $past(rx_valid, 2) || $past(rx_valid, 3) || $past(rx_valid, 4);
  endsequence
  wr_pulse_a: assert property (reg_wr |=> !reg_wr) else $error("long write");
  rd_pulse_a: assert property (reg_rd |=> !reg_rd) else $error("long read");
  err_pulse_a: assert property (frame_error |=> !frame_error) else $error("long drop");
  tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data)) else $error("lost");
  strobe_excl_a: assert property (!(reg_wr && reg_rd)) else $error("both strobes");
  err_quiet_a: assert property (frame_error |-> !reg_wr && !reg_rd) else $error("strobe on drop");
  err_silent_a: assert property (frame_error |=> !tx_valid [*8]) else $error("answer on drop");
  wr_answer_a: assert property (reg_wr && !broadcast |-> ##[1:20] head_out) else $error("no answer");
  wr_cause_a: assert property (reg_wr |-> byte_lately) else $error("early write");
  bcast_quiet_a: assert property (reg_wr && broadcast |-> !tx_valid [*8]) else $error("bcast answer");
endmodule : urf_engine_props
`default_nettype wire

// ==== dv/urf_host.sv ====
// host model: takes answer bytes, stalling one cycle in four
`timescale 1ns/10ps
`default_nettype none
module urf_host
(
  input  wire logic       mclk,     // clock
  input  wire logic       reset,    // reset
  input  wire logic [7:0] tx_data,  // answer byte
  input  wire logic       tx_valid, // offered
  output logic            tx_ready  // taken
);
  logic [7:0] got [$];
  logic [1:0] tick;
  // the stall forces the buffer to hold a byte
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      tick     <= 2'h0;
      tx_ready <= 1'b0;
    end
    else
    begin
      tick     <= tick + 2'h1;
      tx_ready <= (tick != 2'h3);
    end
  end
  // bytes kept in arrival order, whole bytes only
  always @(posedge mclk)
    if (tx_valid && tx_ready)
      got.push_back(tx_data);
endmodule : urf_host
`default_nettype wire

// ==== hdl/urf_engine.sv ====
// register frame protocol engine: decodes command frames and builds answers
// Notes on behaviour
// - a complete eight-byte frame with write operation is one write of a 32-bit register.
// - a good write is answered with a four-byte frame: head, control, address, checksum.
// - bytes go least significant bit first; the byte serialiser outside keeps this order.
// - frames start with 0x7D, control holds address 11:8 high and operation low, third byte address 7:0.
// - write data bytes four to seven carry data 7:0 first up to 31:24 last.
// - the eighth byte is the inverted sum of the seven before it plus 0x33, checked here.
// - the write answer echoes head, write control and low address unchanged.
// - the write answer checksum is the inverted sum of its three bytes plus 0x33.
// - a read is answered with 4*N+4 bytes, N from 1 to 255.
// - the fourth read byte is N, and zero means one word.
// - a read returns at most 255 words at ascending addresses from the target.
// - the read answer is head, control, N, then four bytes per word low first, then checksum.
// - more than 20 ms between two received bytes abandons the frame.
// - a broadcast frame is carried out but gets no answer.
`timescale 1ns/10ps
`default_nettype none
`include "urf_defines.svh"
module urf_engine
(
  input  wire logic        mclk,        // system clock, 100 MHz
  input  wire logic        reset,       // async reset (rx or software reset), active high
  input  wire logic [7:0]  rx_data,     // received byte
  input  wire logic        rx_valid,    // one-cycle pulse per received byte
  input  wire logic        broadcast,   // level: current frame is broadcast
  output logic [7:0]       tx_data,     // byte to transmit
  output logic             tx_valid,    // tx_data offered
  input  wire logic        tx_ready,    // transmitter takes byte
  output logic             reg_wr,      // one-cycle register write strobe
  output logic             reg_rd,      // one-cycle register read strobe
  output logic [11:0]      reg_addr,    // register address
  output logic [31:0]      reg_wdata,   // register write data
  input  wire logic [31:0] reg_rdata,   // read data, valid the cycle after reg_rd
  output logic             frame_error  // one-cycle pulse: frame dropped
);
  // ****************************************************
  // declarations
  // ****************************************************
  urf_pkg::urf_state_t state;
  logic [7:0]  cmd [0:7];
  logic [2:0]  rx_idx;
  logic [31:0] gap_cnt;
  logic        is_bcast;
  logic [7:0]  words;
  logic [7:0]  words_left;
  logic [9:0]  tx_idx;
  logic [9:0]  tx_last;
  logic [31:0] word_buf;
  logic        word_ok;
  logic        rd_pend;
  logic [7:0]  tx_sum;
  logic [7:0]  cur_byte;
  logic        q_ready;
  logic        q_push;
  logic        cmd_good;
  logic [3:0]  cmd_op;
  logic [1:0]  byte_sel;

  // inverted sum plus offset, used for command and answer
  function automatic logic [7:0] csum_fin(input logic [7:0] s);
    csum_fin = ~s + `URF_CSUM_OFFSET;
  endfunction : csum_fin

  function automatic logic [7:0] csum7(input logic [7:0] b0, b1, b2, b3, b4, b5, b6);
    csum7 = csum_fin(b0 + b1 + b2 + b3 + b4 + b5 + b6);
  endfunction : csum7

  // ****************************************************
  // command decode
  // ****************************************************
  assign cmd_op   = cmd[1][3:0];
  assign cmd_good = (cmd[0] == `URF_HEAD_BYTE)
                 && (cmd_op == `URF_OP_WRITE || cmd_op == `URF_OP_READ)
                 && (cmd[7] == csum7(cmd[0], cmd[1], cmd[2], cmd[3], cmd[4], cmd[5], cmd[6]));

  // ****************************************************
  // receive path
  // ****************************************************
  // byte collection and inter-byte timeout
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      rx_idx  <= 3'h0;
      gap_cnt <= 32'h0000_0000;
      for (int i = 0; i < 8; i++) cmd[i] <= 8'h00;
    end
    else if (state == urf_pkg::URF_IDLE || state == urf_pkg::URF_RECV)
    begin
      if (rx_valid)
      begin
        cmd[rx_idx] <= rx_data;
        rx_idx      <= rx_idx + 3'h1;
        gap_cnt     <= 32'h0000_0000;
      end
      else if (state == urf_pkg::URF_RECV)
      begin
        if (gap_cnt >= `URF_GAP_CYCLES)
          rx_idx <= 3'h0;
        else
          gap_cnt <= gap_cnt + 32'h0000_0001;
      end
    end
    else
      rx_idx <= 3'h0;
  end

  // ****************************************************
  // control sequence
  // ****************************************************
  // main state machine; a stalled transmitter holds the send state
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      state       <= urf_pkg::URF_IDLE;
      is_bcast    <= 1'b0;
      frame_error <= 1'b0;
    end
    else
    begin
      frame_error <= 1'b0;
      case (state)
        urf_pkg::URF_IDLE:
          if (rx_valid)
          begin
            state    <= urf_pkg::URF_RECV;
            is_bcast <= broadcast;
          end
        urf_pkg::URF_RECV:
          if (rx_valid && rx_idx == `URF_CMD_LEN)
            state <= urf_pkg::URF_CHECK;
          else if (!rx_valid && gap_cnt >= `URF_GAP_CYCLES)
            state <= urf_pkg::URF_IDLE;
        urf_pkg::URF_CHECK:
          if (!cmd_good)
          begin
            state       <= urf_pkg::URF_IDLE;
            frame_error <= 1'b1;
          end
          else if (is_bcast)
            state <= urf_pkg::URF_IDLE;
          else
            state <= urf_pkg::URF_SEND;
        urf_pkg::URF_SEND:
          if (q_push && tx_idx == tx_last)
            state <= urf_pkg::URF_IDLE;
        default:
          state <= urf_pkg::URF_IDLE;
      endcase
    end
  end

  // register access strobes and read prefetch
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      reg_wr     <= 1'b0;
      reg_rd     <= 1'b0;
      reg_addr   <= 12'h000;
      reg_wdata  <= 32'h0000_0000;
      words      <= 8'h00;
      words_left <= 8'h00;
      rd_pend    <= 1'b0;
      word_ok    <= 1'b0;
      word_buf   <= 32'h0000_0000;
    end
    else
    begin
      reg_wr  <= 1'b0;
      reg_rd  <= 1'b0;
      rd_pend <= reg_rd;
      if (rd_pend)
      begin
        word_buf <= reg_rdata;
        word_ok  <= 1'b1;
      end
      if (state == urf_pkg::URF_CHECK && cmd_good)
      begin
        reg_addr  <= {cmd[1][7:4], cmd[2]};
        reg_wdata <= {cmd[6], cmd[5], cmd[4], cmd[3]};
        if (cmd_op == `URF_OP_WRITE)
          reg_wr <= 1'b1;
        else
        begin
          words      <= (cmd[3] == 8'h00) ? 8'h01 : cmd[3];
          words_left <= (cmd[3] == 8'h00) ? 8'h01 : cmd[3];
          reg_rd     <= 1'b1;
          word_ok    <= 1'b0;
        end
      end
      else if (state == urf_pkg::URF_SEND && q_push && tx_idx >= 10'h003 && tx_idx[1:0] == 2'h2
               && tx_idx != tx_last)
      begin
        // last byte of a word goes out: fetch the next address
        word_ok    <= 1'b0;
        words_left <= words_left - 8'h01;
        if (words_left != 8'h01)
        begin
          reg_addr <= reg_addr + 12'h001;
          reg_rd   <= 1'b1;
        end
      end
    end
  end

  // ****************************************************
  // answer path
  // ****************************************************
  // answer byte selection; data bytes wait until the word is fetched
  always_comb
  begin
    cur_byte = 8'h00;
    if (tx_idx == 10'h000)
      cur_byte = `URF_HEAD_BYTE;
    else if (tx_idx == 10'h001)
      cur_byte = cmd[1];
    else if (tx_idx == 10'h002)
      cur_byte = (cmd_op == `URF_OP_WRITE) ? cmd[2] : words;
    else if (tx_idx == tx_last)
      cur_byte = csum_fin(tx_sum);
    else
      cur_byte = word_buf[8 * byte_sel +: 8];
  end

  // byte within the fetched word; kept two bits wide so index 3 wraps to byte 0, not past the word
  assign byte_sel = tx_idx[1:0] + 2'h1;
  assign tx_last = (cmd_op == `URF_OP_WRITE) ? `URF_WR_RESP_LAST : {words, 2'h3};
  assign q_push  = (state == urf_pkg::URF_SEND) && q_ready
                && (tx_idx < 10'h003 || tx_idx == tx_last || word_ok);

  // byte index and running answer sum
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      tx_idx <= 10'h000;
      tx_sum <= 8'h00;
    end
    else if (state != urf_pkg::URF_SEND)
    begin
      tx_idx <= 10'h000;
      tx_sum <= 8'h00;
    end
    else if (q_push)
    begin
      tx_idx <= tx_idx + 10'h001;
      tx_sum <= tx_sum + cur_byte;
    end
  end

  // buffer towards the byte serialiser, which shifts lsb first
  urf_skid u_skid
  (
    .mclk      (mclk),
    .reset     (reset),
    .in_data   (cur_byte),
    .in_valid  (q_push),
    .in_ready  (q_ready),
    .out_data  (tx_data),
    .out_valid (tx_valid),
    .out_ready (tx_ready)
  );
endmodule : urf_engine
`default_nettype wire

// ==== hdl/urf_skid.sv ====
// two-entry byte buffer with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module urf_skid
(
  input  wire logic       mclk,     // system clock
  input  wire logic       reset,    // async reset, active high
  input  wire logic [7:0] in_data,  // byte from the frame engine
  input  wire logic       in_valid, // in_data is offered
  output logic            in_ready, // a slot is free
  output logic [7:0]      out_data, // byte towards the byte transmitter
  output logic            out_valid,// out_data is offered
  input  wire logic       out_ready // transmitter takes the byte
);
  logic [7:0] mem [0:1];
  logic       wr_ptr;
  logic       rd_ptr;
  logic [1:0] count;
  logic       push;
  logic       pop;

  // handshake terms
  assign in_ready  = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr]; // storage is flip-flops

  // storage write
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      mem[0] <= 8'h00;
      mem[1] <= 8'h00;
    end
    else if (push)
      mem[wr_ptr] <= in_data;
  end

  // pointers and fill level
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
    end
    else
    begin
      if (push) wr_ptr <= ~wr_ptr;
      if (pop)  rd_ptr <= ~rd_ptr;
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : urf_skid
`default_nettype wire

// ==== pkg/urf_defines.svh ====
// constants of the register frame protocol engine
`ifndef URF_DEFINES_SVH
`define URF_DEFINES_SVH
`define URF_HEAD_BYTE      8'h7D
`define URF_OP_WRITE       4'h2
`define URF_OP_READ        4'h1
`define URF_CSUM_OFFSET    8'h33
`define URF_CMD_LEN        3'h7
`define URF_WR_RESP_LAST   10'h003
`define URF_GAP_MS         20
`define URF_CLK_KHZ        100000
`define URF_GAP_CYCLES     (`URF_GAP_MS * `URF_CLK_KHZ)
`endif

// ==== pkg/urf_pkg.sv ====
// types of the register frame protocol engine
package urf_pkg;
  typedef enum logic [2:0] {URF_IDLE, URF_RECV, URF_CHECK, URF_FETCH, URF_SEND} urf_state_t;
endpackage : urf_pkg
